// *** hdl/vc1_link_pkg.sv ***
package vc1_link_pkg;

	// ****************************************
	// widths and field positions
	// ****************************************
	localparam int DATA_W          = 512;
	localparam int BYTES_W         = DATA_W / 8;
	localparam int SIDEBAND_W      = 100;
	localparam int END3_LSB        = 28;
	localparam int END4_LSB        = 32;
	localparam int PARITY_LSB      = 36;
	localparam int ABORT_LSB       = 16;
	localparam int OFFSET_W        = 4;

	// ****************************************
	// credit grants
	// ****************************************
	localparam int TX_CREDITS_256  = 8;
	localparam int TX_CREDITS_512  = 12;
	localparam int CREDIT_W        = 8;
	localparam logic [7:0]  POSTED_HDR_CREDITS   = 8'h40;
	localparam logic [11:0] POSTED_DATA_DEFAULT  = 12'h0c0;
	localparam logic [11:0] POSTED_DATA_LARGE    = 12'h1c0;

	// ****************************************
	// link states, request then acknowledge
	// ****************************************
	typedef enum logic [1:0]
	{
		LINK_STOP       = 2'b00,
		LINK_ACTIVATE   = 2'b10,
		LINK_RUN        = 2'b11,
		LINK_DEACTIVATE = 2'b01
	} link_state_t;

endpackage

// *** hdl/vc1_beat_buffer.sv ***
`timescale 1ns/100ps
module vc1_beat_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)(
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	if (DEPTH != 2)
	begin : g_bad_depth
		$error("beat buffer depth must be 2");
	end

	logic [WIDTH-1:0] store_q [DEPTH];
	logic [1:0]       count_q;
	logic             wr_ptr_q;
	logic             rd_ptr_q;
	logic             push;
	logic             pop;

	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign in_ready_out  = (count_q != 2'h2);
	assign out_valid_out = (count_q != 2'h0);
	assign out_data_out  = store_q[rd_ptr_q];

	always_ff @(posedge sys_clk_in)
	begin
		if (push)
			store_q[wr_ptr_q] <= in_data_in;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			count_q  <= 2'h0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			if (push && !pop)
				count_q <= count_q + 2'h1;
			else if (pop && !push)
				count_q <= count_q - 2'h1;
		end
	end

endmodule

// *** hdl/vc1_credit_link_port.sv ***
// Behaviour
// R1: sideband 31:28 carries third packet's last dword offset, valid with its end flag
// R2: sideband 35:32 carries fourth packet's last dword offset, valid with its end flag
// R3: sideband 99:36 carries odd parity of each data byte
// R4: user may nullify a packet with bad parity as internal error
// R5: receive valid drops mid-packet when no user credit remains
// R6: presentation resumes one cycle after a credit returns
// R7: user may drop transmit valid mid-packet and must resume correctly
// R8: user may instead gather credits for a whole packet first
// R9: transmit grant is 8 credits at 256 bits, 12 at 512
// R10: receiver advertises 64 posted header and c0 or 1c0 data credits
// R11: in Stop all credits are held and no valid data moves
// R12: in Run data and credits flow freely
// R13: Stop to Run passes Activate; Run to Stop passes Deactivate
// R14: each direction's state is its request and acknowledge pair
// R15: deactivation waits until data and credits are quiet; transmit request drops once tx_valid_in is low, tx_credits_q unchecked
// R16: abort flag is raised only while receive valid is high
// R17: pair 00 Stop, 10 Activate, 11 Run, 01 Deactivate
// R18: one beat uses one credit, one pulse restores one; never above grant
`timescale 1ns/100ps
module vc1_credit_link_port #(
	parameter int  DATA_W     = vc1_link_pkg::DATA_W,
	parameter int  RX_CREDITS = 8,
	parameter bit  LARGE_DATA = 1'b0
)(
	input  wire logic                         sys_clk_in,
	input  wire logic                         sys_rst_in,
	// core side receive stream
	input  wire logic                         core_rx_valid_in,
	output logic                              core_rx_ready_out,
	input  wire logic [DATA_W-1:0]            core_rx_data_in,
	input  wire logic [3:0]                   packet_end_flags_in,
	input  wire logic [3:0]                   third_end_dword_offset_in,
	input  wire logic [3:0]                   fourth_end_dword_offset_in,
	input  wire logic [3:0]                   core_rx_abort_in,
	// user side receive stream
	output logic                              rx_valid_out,
	output logic      [DATA_W-1:0]            rx_data_out,
	output logic      [99:0]                  rx_sideband_out,
	output logic      [3:0]                   packet_end_flags_out,
	input  wire logic                         rx_credit_in,
	input  wire logic                         rx_active_req_in,
	output logic                              rx_active_ack_out,
	// user side transmit
	input  wire logic                         tx_valid_in,
	input  wire logic [DATA_W-1:0]            tx_data_in,
	output logic                              tx_credit_out,
	output logic                              tx_active_req_out,
	input  wire logic                         tx_active_ack_in,
	input  wire logic                         tx_enable_in,
	output logic                              tx_beat_valid_out,
	output logic      [DATA_W-1:0]            tx_beat_data_out,
	// advertised flow control
	output logic      [7:0]                   posted_hdr_credits_out,
	output logic      [11:0]                  posted_data_credits_out
);

	localparam int TX_GRANT = (DATA_W == 512) ? vc1_link_pkg::TX_CREDITS_512
	                                          : vc1_link_pkg::TX_CREDITS_256;
	localparam int BUF_W    = DATA_W + 4 + 8 + 4;
	localparam logic [11:0] DATA_ADV = (DATA_W == 512 && !LARGE_DATA)
	                                   ? vc1_link_pkg::POSTED_DATA_DEFAULT
	                                   : vc1_link_pkg::POSTED_DATA_LARGE;

	if (DATA_W != 512 && DATA_W != 256)
	begin : g_bad_width
		$error("data width must be 256 or 512");
	end
	if (RX_CREDITS < 1 || RX_CREDITS > 255)
	begin : g_bad_credits
		$error("receive credits out of range");
	end

	// ****************************************
	// receive link state
	// ****************************************
	vc1_link_pkg::link_state_t rx_state;
	logic                      rx_run;
	logic                      rx_quiet;
	logic [7:0]                rx_credits_q;
	logic                      rx_ack_q;

	assign rx_state          = vc1_link_pkg::link_state_t'({rx_active_req_in, rx_ack_q}); // R14 R17
	assign rx_run            = (rx_state == vc1_link_pkg::LINK_RUN); // R12
	assign rx_active_ack_out = rx_ack_q;

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			rx_ack_q <= 1'b0;
		else
		begin
			case (rx_state)
				vc1_link_pkg::LINK_ACTIVATE:   rx_ack_q <= 1'b1; // R13
				vc1_link_pkg::LINK_DEACTIVATE: if (rx_quiet) rx_ack_q <= 1'b0; // R13 R15
				default:                       rx_ack_q <= rx_ack_q;
			endcase
		end
	end

	// ****************************************
	// receive path: buffer, parity, credits
	// ****************************************
	logic [DATA_W/8-1:0] parity;
	logic [BUF_W-1:0]    buf_in;
	logic [BUF_W-1:0]    buf_out;
	logic                buf_valid;
	logic                buf_take;
	logic                rx_ok;
	logic                buf_in_ready;
	logic                rx_valid_q;
	logic                rx_accept;

	// parity taken from the word leaving the buffer, so it never slips a beat
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W/8; gi++)
		begin : g_par
			assign parity[gi] = ~^buf_out[BUF_W-DATA_W + gi*8 +: 8]; // R3
		end
	endgenerate

	assign buf_in = {core_rx_data_in, packet_end_flags_in, third_end_dword_offset_in,
	                 fourth_end_dword_offset_in, core_rx_abort_in};

	vc1_beat_buffer #(
		.WIDTH (BUF_W),
		.DEPTH (2)
	) u_rx_buffer (
		.sys_clk_in    (sys_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (rx_accept),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (buf_in),
		.out_valid_out (buf_valid),
		.out_ready_in  (buf_take),
		.out_data_out  (buf_out)
	);

	assign rx_accept = core_rx_valid_in && core_rx_ready_out;

	// ready rests a cycle after each accept so a late ready never overfills
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			core_rx_ready_out <= 1'b0;
		else
			core_rx_ready_out <= rx_run && buf_in_ready && !rx_accept; // R11
	end

	// credit available: beat leaves only with a credit in hand
	assign rx_ok    = (rx_credits_q != 8'h0) || rx_credit_in; // R5 R6
	assign buf_take = buf_valid && rx_ok && rx_ack_q; // R11 R15
	assign rx_quiet = !buf_valid && !rx_valid_q && (rx_credits_q == 8'(RX_CREDITS));

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			rx_credits_q <= 8'(RX_CREDITS);
		else if (!rx_run && rx_state == vc1_link_pkg::LINK_STOP)
			rx_credits_q <= 8'(RX_CREDITS); // R11
		else if (buf_take && !rx_credit_in)
			rx_credits_q <= rx_credits_q - 8'h1; // R18
		else if (rx_credit_in && !buf_take && rx_credits_q != 8'(RX_CREDITS))
			rx_credits_q <= rx_credits_q + 8'h1; // R18
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_valid_q           <= 1'b0;
			rx_data_out          <= '0;
			rx_sideband_out      <= '0;
			packet_end_flags_out <= 4'h0;
		end
		else
		begin
			rx_valid_q <= buf_take; // R5
			if (buf_take)
			begin
				rx_data_out          <= buf_out[BUF_W-1 -: DATA_W];
				packet_end_flags_out <= buf_out[15:12];
				rx_sideband_out      <= '0;
				rx_sideband_out[vc1_link_pkg::END3_LSB +: 4] <= buf_out[11:8] & {4{buf_out[14]}}; // R1
				rx_sideband_out[vc1_link_pkg::END4_LSB +: 4] <= buf_out[7:4] & {4{buf_out[15]}}; // R2
				rx_sideband_out[vc1_link_pkg::PARITY_LSB +: DATA_W/8] <= parity; // R3
				rx_sideband_out[vc1_link_pkg::ABORT_LSB +: 4] <= buf_out[3:0]; // R16
			end
			else
				rx_sideband_out[vc1_link_pkg::ABORT_LSB +: 4] <= 4'h0; // R16
		end
	end

	assign rx_valid_out = rx_valid_q;

	// ****************************************
	// transmit link state and credits
	// ****************************************
	vc1_link_pkg::link_state_t tx_state;
	logic [7:0]                tx_credits_q;
	logic                      tx_used;
	logic                      tx_req_q;

	assign tx_state          = vc1_link_pkg::link_state_t'({tx_req_q, tx_active_ack_in}); // R14
	assign tx_active_req_out = tx_req_q;
	assign tx_used           = tx_valid_in && (tx_state == vc1_link_pkg::LINK_RUN)
	                           && tx_credits_q != 8'(TX_GRANT); // R7 R8

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			tx_req_q <= 1'b0;
		else if (tx_enable_in && tx_state == vc1_link_pkg::LINK_STOP)
			tx_req_q <= 1'b1; // R13
		else if (!tx_enable_in && tx_state == vc1_link_pkg::LINK_RUN
		         && !tx_valid_in)
			tx_req_q <= 1'b0; // R15
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_credits_q  <= 8'(TX_GRANT); // R9
			tx_credit_out <= 1'b0;
		end
		else
		begin
			tx_credit_out <= 1'b0;
			if (tx_state == vc1_link_pkg::LINK_RUN && tx_credits_q != 8'h0
			    && !tx_used && tx_enable_in)
			begin
				tx_credit_out <= 1'b1; // R12
				tx_credits_q  <= tx_credits_q - 8'h1;
			end
			else if (tx_used && tx_credits_q != 8'(TX_GRANT))
				tx_credits_q <= tx_credits_q + 8'h1; // R18
			else if (tx_state == vc1_link_pkg::LINK_STOP)
				tx_credits_q <= 8'(TX_GRANT); // R11
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_beat_valid_out <= 1'b0;
			tx_beat_data_out  <= '0;
		end
		else
		begin
			tx_beat_valid_out <= tx_used; // R11
			if (tx_valid_in)
				tx_beat_data_out <= tx_data_in;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			posted_hdr_credits_out  <= vc1_link_pkg::POSTED_HDR_CREDITS; // R10
			posted_data_credits_out <= DATA_ADV; // R10
		end
		else
		begin
			posted_hdr_credits_out <= vc1_link_pkg::POSTED_HDR_CREDITS;
			if (DATA_W == 512 && !LARGE_DATA)
				posted_data_credits_out <= vc1_link_pkg::POSTED_DATA_DEFAULT; // R10
			else
				posted_data_credits_out <= vc1_link_pkg::POSTED_DATA_LARGE;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	no_credit_stall_a: assert property (rx_credits_q == 8'h0 && !rx_credit_in |=> !rx_valid_out) // R5
		else $error("receive valid without credit");
	resume_one_a: assert property (rx_credits_q == 8'h0 && rx_credit_in && buf_valid
		&& rx_run |=> rx_valid_out) // R6
		else $error("resume not one cycle after credit");
	stop_quiet_a: assert property (rx_state == vc1_link_pkg::LINK_STOP |=> !buf_take) // R11
		else $error("data moved in stop");
	rx_credit_cap_a: assert property (rx_credits_q <= 8'(RX_CREDITS)) // R18
		else $error("receive credits above grant");
	tx_credit_cap_a: assert property (tx_credits_q <= 8'(TX_GRANT)) // R9
		else $error("transmit credits above grant");
	abort_valid_a: assert property (rx_sideband_out[19:16] != 4'h0 |-> rx_valid_out) // R16
		else $error("abort without valid");
	end3_gate_a: assert property (!packet_end_flags_out[2] |-> rx_sideband_out[31:28] == 4'h0) // R1
		else $error("third offset without end flag");
	end4_gate_a: assert property (!packet_end_flags_out[3] |-> rx_sideband_out[35:32] == 4'h0) // R2
		else $error("fourth offset without end flag");
	ack_follow_a: assert property (rx_state == vc1_link_pkg::LINK_ACTIVATE |=> rx_active_ack_out) // R13
		else $error("ack did not follow request");

	run_cov: cover property (rx_state == vc1_link_pkg::LINK_RUN ##1 rx_valid_out);
	stall_cov: cover property (rx_valid_out ##1 rx_credits_q == 8'h0);
	deact_cov: cover property (rx_state == vc1_link_pkg::LINK_DEACTIVATE ##1 !rx_active_ack_out);
	tx_beat_cov: cover property (tx_credit_out ##1 tx_beat_valid_out);

endmodule

// *** test/vc1_user_model.sv ***
`timescale 1ns/100ps
module vc1_user_model (
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic rx_on_in,
	input  wire logic hold_in,
	input  wire logic rx_valid_in,
	input  wire logic tx_active_req_in,
	output logic      rx_credit_out,
	output logic      rx_active_req_out,
	output logic      tx_active_ack_out
);
	logic [7:0] owed_q;
	logic       give;

	// ****************************************
	// activation handshake
	// ****************************************
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_active_req_out <= 1'b0;
			tx_active_ack_out <= 1'b0;
		end
		else
		begin
			rx_active_req_out <= rx_on_in;
			tx_active_ack_out <= tx_active_req_in;
		end
	end

	// ****************************************
	// credit return, one pulse per beat
	// ****************************************
	assign give = !hold_in && (owed_q != 8'h00);
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			owed_q        <= 8'h00;
			rx_credit_out <= 1'b0;
		end
		else
		begin
			rx_credit_out <= give;
			owed_q        <= owed_q + 8'(rx_valid_in) - 8'(give);
		end
	end
endmodule

// *** test/vc1_credit_link_port_tb_top.sv ***
`timescale 1ns/100ps
module vc1_credit_link_port_tb_top;
	localparam int RXC = 2;
	typedef struct packed {
		logic [31:0] w;
		logic [3:0]  fl;
		logic [3:0]  o3;
		logic [3:0]  o4;
		logic [3:0]  ab;
	} row_t;
	logic         sys_clk_in;
	logic         sys_rst_in = 1'b1;
	logic         core_rx_valid_in = 1'b0;
	logic         core_rx_ready_out, rx_valid_out, rx_credit_in, rx_active_req_in;
	logic         rx_active_ack_out, tx_credit_out, tx_active_req_out, tx_active_ack_in;
	logic         tx_valid_in = 1'b0;
	logic         tx_enable_in = 1'b0;
	logic         rx_on = 1'b0;
	logic         hold = 1'b0;
	logic         tx_beat_valid_out;
	logic [511:0] core_rx_data_in = '0;
	logic [511:0] tx_data_in = '0;
	logic [511:0] rx_data_out, tx_beat_data_out;
	logic [3:0]   packet_end_flags_in = '0;
	logic [3:0]   third_end_dword_offset_in = '0;
	logic [3:0]   fourth_end_dword_offset_in = '0;
	logic [3:0]   core_rx_abort_in = '0;
	logic [3:0]   packet_end_flags_out;
	logic [99:0]  rx_sideband_out;
	logic [7:0]   posted_hdr_credits_out;
	logic [11:0]  posted_data_credits_out;
	logic [511:0] txq[$];
	int           n_mismatch, total_checks, cnt, n_rxv, n_txc, base;
	row_t         rows [4] = '{
		'{32'h0000_0000, 4'h0, 4'h5, 4'h6, 4'h0},
		'{32'hffff_ffff, 4'h4, 4'ha, 4'h3, 4'h1},
		'{32'h8001_7f03, 4'h8, 4'h9, 4'hc, 4'h0},
		'{32'h1234_a5c3, 4'hf, 4'hf, 4'h1, 4'h8}};

	vc1_credit_link_port #(.RX_CREDITS(RXC)) i_vc1_credit_link_port (
		.sys_clk_in                 (sys_clk_in),
		.sys_rst_in                 (sys_rst_in),
		.core_rx_valid_in           (core_rx_valid_in),
		.core_rx_ready_out          (core_rx_ready_out),
		.core_rx_data_in            (core_rx_data_in),
		.packet_end_flags_in        (packet_end_flags_in),
		.third_end_dword_offset_in  (third_end_dword_offset_in),
		.fourth_end_dword_offset_in (fourth_end_dword_offset_in),
		.core_rx_abort_in           (core_rx_abort_in),
		.rx_valid_out               (rx_valid_out),
		.rx_data_out                (rx_data_out),
		.rx_sideband_out            (rx_sideband_out),
		.packet_end_flags_out       (packet_end_flags_out),
		.rx_credit_in               (rx_credit_in),
		.rx_active_req_in           (rx_active_req_in),
		.rx_active_ack_out          (rx_active_ack_out),
		.tx_valid_in                (tx_valid_in),
		.tx_data_in                 (tx_data_in),
		.tx_credit_out              (tx_credit_out),
		.tx_active_req_out          (tx_active_req_out),
		.tx_active_ack_in           (tx_active_ack_in),
		.tx_enable_in               (tx_enable_in),
		.tx_beat_valid_out          (tx_beat_valid_out),
		.tx_beat_data_out           (tx_beat_data_out),
		.posted_hdr_credits_out     (posted_hdr_credits_out),
		.posted_data_credits_out    (posted_data_credits_out)
	);
	vc1_user_model i_vc1_user_model (
		.sys_clk_in        (sys_clk_in),
		.sys_rst_in        (sys_rst_in),
		.rx_on_in          (rx_on),
		.hold_in           (hold),
		.rx_valid_in       (rx_valid_out),
		.tx_active_req_in  (tx_active_req_out),
		.rx_credit_out     (rx_credit_in),
		.rx_active_req_out (rx_active_req_in),
		.tx_active_ack_out (tx_active_ack_in)
	);

	// ****************************************
	// clock, monitors, helpers
	// ****************************************
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in)
	begin
		n_rxv += int'(rx_valid_out === 1'b1);
		n_txc += int'(tx_credit_out === 1'b1);
		if (tx_beat_valid_out === 1'b1)
			txq.push_back(tx_beat_data_out);
	end

	function automatic logic [99:0] exp_sb(row_t r);
		logic [99:0]  s;
		logic [511:0] d;
		s = '0;
		d = {16{r.w}};
		s[19:16] = r.ab;
		if (r.fl[2])
			s[31:28] = r.o3;
		if (r.fl[3])
			s[35:32] = r.o4;
		for (int i = 0; i < 64; i++)
			s[36+i] = ~^d[8*i +: 8];
		return s;
	endfunction

	task automatic chk(string nm, logic [511:0] seen, logic [511:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick();
		@(posedge sys_clk_in);
	endtask

	task automatic send_rx(row_t r);
		core_rx_valid_in           <= 1'b1;
		core_rx_data_in            <= {16{r.w}};
		packet_end_flags_in        <= r.fl;
		third_end_dword_offset_in  <= r.o3;
		fourth_end_dword_offset_in <= r.o4;
		core_rx_abort_in           <= r.ab;
		cnt = 0;
		do
		begin
			tick();
			cnt++;
		end
		while (core_rx_ready_out !== 1'b1 && cnt < 50);
		if (cnt >= 50)
			n_mismatch++;
	endtask

	task automatic wait_for(ref logic s, input logic v);
		cnt = 0;
		while (s !== v && cnt < 40)
		begin
			tick();
			cnt++;
		end
		if (cnt >= 40)
			n_mismatch++;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		close_out();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		repeat (12) tick();
		sys_rst_in <= 1'b0;
		tick();
		chk("hdr credits", posted_hdr_credits_out, 8'h40);
		chk("data credits", posted_data_credits_out, 12'h0c0);
		chk("ready in stop", core_rx_ready_out, 1'b0);
		rx_on <= 1'b1;
		wait_for(rx_active_ack_out, 1'b1);
		chk("rx ack", rx_active_ack_out, 1'b1);
		foreach (rows[k])
		begin
			send_rx(rows[k]);
			core_rx_valid_in <= 1'b0;
			wait_for(rx_valid_out, 1'b1);
			chk("rx data", rx_data_out, {16{rows[k].w}});
			chk("sideband", rx_sideband_out, exp_sb(rows[k]));
			chk("end flags", packet_end_flags_out, rows[k].fl);
			for (int i = 0; i < 64; i++)
				chk("byte parity", 512'(^{rx_data_out[8*i +: 8], rx_sideband_out[36+i]}), 512'h1);
		end
		repeat (6) tick();
		hold <= 1'b1;
		base = n_rxv;
		for (int k = 0; k < 3; k++)
			send_rx(rows[k]);
		core_rx_valid_in <= 1'b0;
		repeat (12) tick();
		chk("stalled beats", n_rxv - base, RXC);
		hold <= 1'b0;
		wait_for(rx_credit_in, 1'b1);
		base = n_rxv;
		repeat (2) tick();
		chk("resume", n_rxv - base, 1);
		repeat (8) tick();
		rx_on <= 1'b0;
		wait_for(rx_active_ack_out, 1'b0);
		chk("rx ack clear", rx_active_ack_out, 1'b0);
		chk("ready after stop", core_rx_ready_out, 1'b0);
		base = n_txc;
		tx_enable_in <= 1'b1;
		repeat (40) tick();
		chk("tx grant", n_txc - base, 12);
		chk("tx req", tx_active_req_out, 1'b1);
		base = n_txc;
		tx_valid_in <= 1'b1;
		tx_data_in  <= {16{32'h5a5a_0f0f}};
		tick();
		tx_valid_in <= 1'b0;
		tick();
		tx_valid_in <= 1'b1;
		tx_data_in  <= {16{32'hc3c3_9696}};
		tick();
		tx_valid_in <= 1'b0;
		repeat (8) tick();
		chk("tx beats", txq.size(), 2);
		chk("tx beat a", txq[0], {16{32'h5a5a_0f0f}});
		chk("tx beat b", txq[1], {16{32'hc3c3_9696}});
		chk("tx returned", n_txc - base, 2);
		tx_enable_in <= 1'b0;
		wait_for(tx_active_req_out, 1'b0);
		chk("tx req clear", tx_active_req_out, 1'b0);
		tx_valid_in <= 1'b1;
		tick();
		tx_valid_in <= 1'b0;
		repeat (4) tick();
		chk("tx ignored", txq.size(), 2);
		sys_rst_in <= 1'b1;
		repeat (2) tick();
		chk("reset valid", rx_valid_out, 1'b0);
		chk("reset req", tx_active_req_out, 1'b0);
		close_out();
	end
endmodule
